// >>> flash_ctl_pkg.sv
// Package of command codes, status bit positions and bus timing for the flash controller
package flash_ctl_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_AUTOSEL   = 8'h90;
  localparam logic [7:0] CMD_ERASE     = 8'h30;
  localparam logic [7:0] CMD_PROG      = 8'h10;
  localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 16'h0001;
  localparam int POLL_BIT    = 7;
  localparam int FLIP_BIT    = 6;
  localparam int FAIL_BIT    = 5;
  localparam int T_STROBE_NS = 60;
  localparam int CLK_NS      = 20;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_PROG  = 3'h1,
    OP_ERASE = 3'h2,
    OP_ID    = 3'h3,
    OP_RESET = 3'h4
  } op_t;
endpackage

// >>> flash_bus_if.sv
// Interface joining the sequencer to the bus cycle engine
`timescale 1ns/1ps
interface flash_bus_if;
  logic        start;
  logic        wr;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        done;
  modport seq (output start, output wr, output addr, output wdata, input rdata, input done);
  modport eng (input start, input wr, input addr, input wdata, output rdata, output done);
endinterface

// >>> flash_cycle.sv
// Bus cycle engine: one write or read cycle on the flash pins
`timescale 1ns/1ps
module flash_cycle
  import flash_ctl_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  flash_bus_if.eng  bus,
  input  wire logic [7:0] i_dq,
  output logic [15:0] o_a,
  output logic [7:0]  o_dq,
  output logic        o_dq_oe,
  output logic        o_ce_n,
  output logic        o_oe_n,
  output logic        o_we_n
);
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_ACT = 3'b010, S_REC = 3'b100} cyc_t;
  cyc_t       st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic       wr_r, wr_nxt;
  logic [7:0] s1_r, s2_r, s3_r, rd_r, rd_nxt;
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    case (st_r)
      S_IDLE: if (bus.start) begin
        st_nxt  = S_ACT;
        wr_nxt  = bus.wr;
        cnt_nxt = 4'(STROBE_CYC + 2);
      end
      S_ACT: if (cnt_r == 4'h0) begin
        st_nxt  = S_REC;
        cnt_nxt = 4'(STROBE_CYC);
        if (s2_r == s3_r) rd_nxt = s3_r;
      end else cnt_nxt = cnt_r - 4'h1;
      S_REC: if (cnt_r == 4'h0) st_nxt = S_IDLE;
             else cnt_nxt = cnt_r - 4'h1;
      default: st_nxt = S_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= S_IDLE; cnt_r <= 4'h0; wr_r <= 1'b0; rd_r <= 8'h00;
      s1_r <= 8'h00; s2_r <= 8'h00; s3_r <= 8'h00;
      o_a <= 16'h0000; o_dq <= 8'h00; o_dq_oe <= 1'b0;
      o_ce_n <= 1'b1; o_oe_n <= 1'b1; o_we_n <= 1'b1;
    end else if (i_ce) begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; wr_r <= wr_nxt; rd_r <= rd_nxt;
      s1_r <= i_dq; s2_r <= s1_r; s3_r <= s2_r;
      if (st_r == S_IDLE && bus.start) begin
        o_a <= bus.addr; o_dq <= bus.wdata; o_dq_oe <= bus.wr; o_ce_n <= 1'b0;
      end
      o_we_n <= !(st_nxt == S_ACT && wr_nxt);
      o_oe_n <= !(st_nxt == S_ACT && !wr_nxt);
      if (st_nxt == S_IDLE) begin
        o_ce_n <= 1'b1; o_dq_oe <= 1'b0;
      end
    end
  end
  assign bus.done  = (st_r == S_REC) && (cnt_r == 4'h0);
  assign bus.rdata = rd_r;
endmodule // flash_cycle

// >>> flash_status_reset_autoselect.sv
// Host controller sequencing commands and status polling of a bulk-erase flash
`timescale 1ns/1ps
// Function
// - Recheck completion bit after failure seen
// - Read data back from finished devices
// - Reset twice after program setup
// - Single reset aborts other commands
// - Host reset writes the reset code, then the read code
// - Auto-select code enters identification mode
// - Identification persists until next command
// - Erase needs erase code twice
// - Write after setup starts program
module flash_status_reset_autoselect
  import flash_ctl_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic                 i_req,
  input  wire flash_ctl_pkg::op_t   i_op,
  input  wire logic [15:0]          i_addr,
  input  wire logic [7:0]           i_data,
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_fail,
  output logic [7:0]                o_rdata,
  input  wire logic [7:0]           i_dq,
  output logic [15:0]               o_a,
  output logic [7:0]                o_dq,
  output logic                      o_dq_oe,
  output logic                      o_ce_n,
  output logic                      o_oe_n,
  output logic                      o_we_n
);
  import flash_ctl_pkg::*;
  // ************************************************
  // Sequencer
  // ************************************************
  typedef enum logic [6:0] {
    Q_IDLE = 7'b0000001, Q_CMD1 = 7'b0000010, Q_CMD2 = 7'b0000100,
    Q_POLL = 7'b0001000, Q_READ = 7'b0010000, Q_CHK  = 7'b0100000,
    Q_FIN  = 7'b1000000
  } seq_t;
  flash_bus_if bus ();
  seq_t        st_r, st_nxt;
  op_t         op_r, op_nxt;
  logic [15:0] a_r, a_nxt;
  logic [7:0]  d_r, d_nxt, rd_r, rd_nxt;
  logic        fail_r, fail_nxt, done_r, done_nxt, go_r, go_nxt;
  function automatic logic poll_ok(input op_t op, input logic [7:0] v, input logic [7:0] d);
    poll_ok = (op == OP_ERASE) ? v[POLL_BIT] : (v[POLL_BIT] == d[POLL_BIT]);
  endfunction
  always_comb begin
    st_nxt = st_r; op_nxt = op_r; a_nxt = a_r; d_nxt = d_r; rd_nxt = rd_r;
    fail_nxt = fail_r; done_nxt = 1'b0; go_nxt = 1'b0;
    case (st_r)
      Q_IDLE: if (i_req) begin
        op_nxt = i_op; a_nxt = i_addr; d_nxt = i_data; fail_nxt = 1'b0; go_nxt = 1'b1;
        st_nxt = (i_op == OP_READ) ? Q_READ : Q_CMD1;
      end
      Q_CMD1: if (bus.done) begin
        go_nxt = (op_r != OP_ID);
        st_nxt = (op_r == OP_ID) ? Q_FIN : Q_CMD2;
      end
      Q_CMD2: if (bus.done) begin
        go_nxt = (op_r != OP_RESET);
        st_nxt = (op_r == OP_RESET) ? Q_FIN : Q_POLL;
      end
      Q_POLL: if (bus.done) begin
        go_nxt = 1'b1;
        if (bus.rdata[FAIL_BIT]) st_nxt = Q_CHK;
        else if (poll_ok(op_r, bus.rdata, d_r)) st_nxt = Q_READ;
      end
      Q_CHK: if (bus.done) begin
        if (!poll_ok(op_r, bus.rdata, d_r)) fail_nxt = 1'b1;
        go_nxt = 1'b1;
        st_nxt = Q_READ;
      end
      Q_READ: if (bus.done) begin
        rd_nxt = bus.rdata;
        st_nxt = Q_FIN;
      end
      Q_FIN: begin
        done_nxt = 1'b1;
        st_nxt = Q_IDLE;
      end
      default: st_nxt = Q_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= Q_IDLE; op_r <= OP_READ; a_r <= 16'h0000; d_r <= 8'h00; rd_r <= 8'h00;
      fail_r <= 1'b0; done_r <= 1'b0; go_r <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt; op_r <= op_nxt; a_r <= a_nxt; d_r <= d_nxt; rd_r <= rd_nxt;
      fail_r <= fail_nxt; done_r <= done_nxt; go_r <= go_nxt;
    end
  end
  // ************************************************
  // Cycle request mapping
  // ************************************************
  logic       is_wr;
  logic [7:0] wd;
  always_comb begin
    is_wr = 1'b0;
    wd    = CMD_READ;
    case (st_r)
      Q_CMD1: begin
        is_wr = 1'b1;
        case (op_r)
          OP_PROG:  wd = CMD_PROG;
          OP_ERASE: wd = CMD_ERASE;
          OP_ID:    wd = CMD_AUTOSEL;
          default:  wd = CMD_RESET;
        endcase
      end
      Q_CMD2: begin
        is_wr = 1'b1;
        case (op_r)
          OP_PROG:  wd = d_r;
          OP_ERASE: wd = CMD_ERASE;
          default:  wd = CMD_READ;
        endcase
      end
      default: is_wr = 1'b0;
    endcase
  end
  assign bus.start = go_r;
  assign bus.wr    = is_wr;
  assign bus.addr  = a_r;
  assign bus.wdata = wd;
  flash_cycle u_cycle (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .bus     (bus),
    .i_dq    (i_dq),
    .o_a     (o_a),
    .o_dq    (o_dq),
    .o_dq_oe (o_dq_oe),
    .o_ce_n  (o_ce_n),
    .o_oe_n  (o_oe_n),
    .o_we_n  (o_we_n)
  );
  assign o_busy  = (st_r != Q_IDLE);
  assign o_done  = done_r;
  assign o_fail  = fail_r;
  assign o_rdata = rd_r;
  // ************************************************
  // Checks
  // ************************************************
  property p_idle_after_done;
    @(posedge i_clk) disable iff (i_rst) done_r |-> !o_busy;
  endproperty
  a_idle_after_done: assert property (p_idle_after_done)
    else $error("busy after done");

  property p_reset_first;
    @(posedge i_clk) disable iff (i_rst)
      (st_r == Q_CMD1 && op_r == OP_RESET) |-> bus.wdata == CMD_RESET && bus.wr;
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("first reset write wrong");
  property p_reset_two;
    @(posedge i_clk) disable iff (i_rst)
      (st_r == Q_CMD2 && op_r == OP_RESET) |-> bus.wdata == CMD_READ && bus.wr;
  endproperty
  a_reset_two: assert property (p_reset_two)
    else $error("second reset write missing");

  property p_erase_code;
    @(posedge i_clk) disable iff (i_rst)
      (st_r == Q_CMD2 && op_r == OP_ERASE) |-> bus.wdata == CMD_ERASE;
  endproperty
  a_erase_code: assert property (p_erase_code)
    else $error("erase code wrong");

  property p_prog_setup;
    @(posedge i_clk) disable iff (i_rst)
      (st_r == Q_CMD1 && op_r == OP_PROG) |-> bus.wr && bus.wdata == CMD_PROG;
  endproperty
  a_prog_setup: assert property (p_prog_setup)
    else $error("program setup write wrong");
  property p_id_single;
    @(posedge i_clk) disable iff (i_rst)
      (st_r == Q_CMD1 && op_r == OP_ID && bus.done && i_ce) |=> st_r == Q_FIN && !bus.start;
  endproperty
  a_id_single: assert property (p_id_single)
    else $error("identify sent extra cycle");

  property p_fail_cause;
    @(posedge i_clk) disable iff (i_rst) $rose(fail_r) |-> $past(st_r) == Q_CHK;
  endproperty
  a_fail_cause: assert property (p_fail_cause)
    else $error("fail without check");

  sequence s_fail_seen;
    st_r == Q_POLL && bus.done && i_ce && bus.rdata[FAIL_BIT];
  endsequence
  property p_fail_to_chk;
    @(posedge i_clk) disable iff (i_rst) s_fail_seen |=> st_r == Q_CHK && bus.start;
  endproperty
  a_fail_to_chk: assert property (p_fail_to_chk)
    else $error("failure bit not rechecked");

  sequence s_chk_done;
    st_r == Q_CHK && bus.done && i_ce;
  endsequence
  property p_recheck_then_read;
    @(posedge i_clk) disable iff (i_rst) s_chk_done |=> st_r == Q_READ && bus.start;
  endproperty
  a_recheck_then_read: assert property (p_recheck_then_read)
    else $error("no final read after recheck");
endmodule // flash_status_reset_autoselect

// >>> flash_dev_model.sv
// Behavioural model of the byte-wide flash device on the controller's far side
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int         POLLS    = 3,
  parameter logic [7:0] MFR_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C  // Arbitrary value
) (
  input  wire logic [15:0] i_a,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_fail,
  output logic [7:0]       o_dq
);
  typedef enum logic [2:0] {S_RD, S_ID, S_PSET, S_PBUSY, S_ESET, S_EBUSY} dev_st_t;
  dev_st_t     st = S_RD;
  logic [7:0]  mem [0:255];
  logic [7:0]  tgt = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [7:0]  rdval;
  logic [15:0] wa = 16'h0000;
  logic        flip = 1'b0;
  logic        bad = 1'b0;
  int          cnt = 0;
  wire         wr = ~i_ce_n & ~i_we_n;
  wire         rd = ~i_ce_n & ~i_oe_n;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  always_comb begin
    case (st)
      S_PBUSY: rdval = {~tgt[7], flip, bad, mem[i_a[7:0]][4:0]};
      S_EBUSY: rdval = {1'b0, flip, bad, 5'h00};
      S_ID:    rdval = i_a[0] ? DEV_CODE : MFR_CODE;
      default: rdval = mem[i_a[7:0]];
    endcase
  end
  // Released bus shows the inverse of the last value
  assign o_dq = rd ? rdval : ~last;
  always @(posedge wr) wa = i_a;
  always @(negedge wr) begin
    cnt = 0;
    case (st)
      S_PSET: begin
        tgt = i_dq;
        mem[wa[7:0]] = mem[wa[7:0]] & i_dq;
        st = S_PBUSY;
      end
      S_ESET: st = (i_dq == 8'h30) ? S_EBUSY : S_RD;
      S_PBUSY, S_EBUSY: if (!bad && (i_dq == 8'hFF || i_dq == 8'h00)) st = S_RD;
      default: begin
        if (i_dq == 8'h10 || i_dq == 8'h50) st = S_PSET;
        else if (i_dq == 8'h30) st = S_ESET;
        else if (i_dq == 8'h80 || i_dq == 8'h90) st = S_ID;
        else if (i_dq == 8'h00 || i_dq == 8'hFF) st = S_RD;
      end
    endcase
  end
  always @(negedge rd) begin
    last = rdval;
    if (st == S_PBUSY || st == S_EBUSY) begin
      flip = ~flip;
      cnt++;
      if (cnt >= POLLS && i_fail) bad = 1'b1;
      else if (cnt >= POLLS) begin
        if (st == S_EBUSY) for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
        st = S_RD;
      end
    end
  end
endmodule // flash_dev_model

// >>> flash_status_reset_autoselect_bench.sv
// Self-checking bench for the flash status, reset and auto-select controller
`timescale 1ns/1ps
module flash_status_reset_autoselect_bench;
  import flash_ctl_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_req = 1'b0;
  logic        i_fail = 1'b0;
  logic        i_ce = 1'b1;
  int          freeze = 0;
  op_t         i_op = OP_READ;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] o_a;
  logic [7:0]  i_data = 8'h00;
  logic [7:0]  o_rdata, o_dq, dev_dq, pin_dq;
  logic        o_busy, o_done, o_fail, o_dq_oe, o_ce_n, o_oe_n, o_we_n;
  int          error_cnt = 0;
  int          tests_run = 0;
  assign pin_dq = o_dq_oe ? o_dq : dev_dq;
  always #10 i_clk = ~i_clk;
  flash_status_reset_autoselect dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .i_data(i_data), .o_busy(o_busy), .o_done(o_done),
    .o_fail(o_fail), .o_rdata(o_rdata), .i_dq(pin_dq), .o_a(o_a), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));
  flash_dev_model #(.POLLS(3), .MFR_CODE(8'hA5), .DEV_CODE(8'h3C)) dev (
    .i_a(o_a), .i_dq(o_dq), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_fail(i_fail), .o_dq(dev_dq));
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input op_t op, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(negedge i_clk);
    i_req = 1'b1;
    i_op = op;
    i_addr = a;
    i_data = d;
    @(negedge i_clk);
    i_req = 1'b0;
    if (freeze > 0) begin
      i_ce = 1'b0;
      repeat (freeze) @(negedge i_clk);
      chk({6'h00, o_busy, o_done}, 8'h02);
      i_ce = 1'b1;
    end
    n = 0;
    while (o_done !== 1'b1 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      $display("[FAIL] %0t no completion", $time);
      report_and_stop();
    end
    $display("Test step %s finished", op.name());
  endtask
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    run(OP_READ, 16'h0005, 8'h00);
    chk(o_rdata, 8'hFF);
    run(OP_PROG, 16'h0005, 8'h5A);
    chk({7'h00, o_fail}, 8'h00);
    chk(o_rdata, 8'h5A);
    run(OP_ID, 16'h0000, 8'h00);
    run(OP_READ, ID_MFR_ADDR, 8'h00);
    chk(o_rdata, 8'hA5);
    run(OP_READ, ID_DEV_ADDR, 8'h00);
    chk(o_rdata, 8'h3C);
    run(OP_RESET, 16'h0000, 8'h00);
    freeze = 20;
    run(OP_READ, 16'h0005, 8'h00);
    freeze = 0;
    chk(o_rdata, 8'h5A);
    run(OP_ERASE, 16'h0000, 8'h00);
    chk(o_rdata, 8'hFF);
    run(OP_READ, 16'h0005, 8'h00);
    chk(o_rdata, 8'hFF);
    i_fail = 1'b1;
    run(OP_PROG, 16'h0007, 8'h00);
    chk({7'h00, o_fail}, 8'h01);
    chk({7'h00, o_busy}, 8'h00);
    report_and_stop();
  end
endmodule // flash_status_reset_autoselect_bench
